// >>> logic/uedb_consts.svh
`ifndef UEDB_CONSTS_SVH
`define UEDB_CONSTS_SVH

// global registers of the descriptor block
`define UEDB_ADDR_IRQ_STATUS 8'h00
`define UEDB_ADDR_IRQ_MASK 8'h01
// endpoint n (1..3) occupies addresses n*8 .. n*8+6
`define UEDB_EP_SHIFT 3
`define UEDB_REG_CONFIG 3'h0
`define UEDB_REG_X_BASE 3'h1
`define UEDB_REG_X_COUNT 3'h2
`define UEDB_REG_Y_BASE 3'h3
`define UEDB_REG_Y_COUNT 3'h4
`define UEDB_REG_IN_SIZE 3'h5
`define UEDB_REG_OUT_SIZE 3'h6
// field positions of in_endpoint_config
`define UEDB_CFG_IRQ_EN 2
`define UEDB_CFG_STALL 3
`define UEDB_CFG_DOUBLE_BUF 4
`define UEDB_CFG_TOGGLE 5
`define UEDB_CFG_ISO 6
`define UEDB_CFG_MGR_EN 7
// empty flag of a byte count register
`define UEDB_CNT_NAK 7
// 7-bit size fields, top bit reserved
`define UEDB_FIELD_MASK 8'h7F
`define UEDB_CFG_RW_MASK 8'hFC
// reset values of every descriptor register
`define UEDB_REG_RESET 8'h00
`define UEDB_ENDPOINTS 3

`endif

// >>> logic/uedb_pkg.sv
package uedb_pkg;
  // answer of the device to a token
  typedef enum logic [2:0] {
    UEDB_RSP_NONE = 3'h0,
    UEDB_RSP_DATA = 3'h1,
    UEDB_RSP_NAK = 3'h2,
    UEDB_RSP_STALL = 3'h3,
    UEDB_RSP_SIZE = 3'h4
  } uedb_rsp_t;

  typedef enum logic {
    UEDB_D_IDLE = 1'b0,
    UEDB_D_WAIT_ACK = 1'b1
  } uedb_dev_state_t;

  typedef enum logic {
    UEDB_H_IDLE = 1'b0,
    UEDB_H_WAIT_RSP = 1'b1
  } uedb_host_state_t;
endpackage : uedb_pkg

// >>> logic/uedb_link_if.sv
`timescale 1ns/1ns
interface uedb_link_if;
  import uedb_pkg::*;
  logic tok_valid;
  logic tok_in;
  logic [1:0] tok_ep;
  logic rsp_valid;
  uedb_rsp_t rsp_code;
  logic rsp_pid;
  logic [10:0] rsp_addr;
  logic [6:0] rsp_count;
  logic hs_ack;

  modport device (
    input tok_valid, tok_in, tok_ep, hs_ack,
    output rsp_valid, rsp_code, rsp_pid, rsp_addr, rsp_count
  );
  modport host (
    output tok_valid, tok_in, tok_ep, hs_ack,
    input rsp_valid, rsp_code, rsp_pid, rsp_addr, rsp_count
  );
endinterface : uedb_link_if

// >>> logic/uedb_entry.sv
`timescale 1ns/1ns
`include "uedb_consts.svh"
// one endpoint descriptor entry: software and buffer manager share it
module uedb_entry (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [2:0] sel_i,
  input wire logic [7:0] wdata_i,
  input wire logic stall_clr_i,
  input wire logic done_i,
  input wire logic done_y_i,
  output logic [7:0] cfg_o,
  output logic [7:0] x_base_o,
  output logic [7:0] x_count_o,
  output logic [7:0] y_base_o,
  output logic [7:0] y_count_o,
  output logic [7:0] in_size_o,
  output logic [7:0] out_size_o,
  output logic [7:0] rdata_o
);
  logic cfg_wr;
  assign cfg_wr = wr_i && sel_i == `UEDB_REG_CONFIG;

  // configuration: a software write wins over the hardware updates
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_o <= `UEDB_REG_RESET;
    end else if (cfg_wr) begin
      cfg_o <= wdata_i & `UEDB_CFG_RW_MASK;
    end else begin
      if (stall_clr_i) begin
        cfg_o[`UEDB_CFG_STALL] <= 1'b0;
      end
      if (done_i) begin
        cfg_o[`UEDB_CFG_TOGGLE] <= ~cfg_o[`UEDB_CFG_TOGGLE];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_base_o <= `UEDB_REG_RESET;
      y_base_o <= `UEDB_REG_RESET;
    end else if (wr_i) begin
      if (sel_i == `UEDB_REG_X_BASE) begin
        x_base_o <= wdata_i;
      end
      if (sel_i == `UEDB_REG_Y_BASE) begin
        y_base_o <= wdata_i;
      end
    end
  end

  // byte counts: the buffer manager sets empty on completion, and that set wins over a write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_count_o <= `UEDB_REG_RESET;
      y_count_o <= `UEDB_REG_RESET;
    end else begin
      if (wr_i && sel_i == `UEDB_REG_X_COUNT) begin
        x_count_o <= {wdata_i[7] | (done_i & ~done_y_i), wdata_i[6:0]};
      end else if (done_i && !done_y_i) begin
        x_count_o[`UEDB_CNT_NAK] <= 1'b1;
      end
      if (wr_i && sel_i == `UEDB_REG_Y_COUNT) begin
        y_count_o <= {wdata_i[7] | (done_i & done_y_i), wdata_i[6:0]};
      end else if (done_i && done_y_i) begin
        y_count_o[`UEDB_CNT_NAK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_size_o <= `UEDB_REG_RESET;
      out_size_o <= `UEDB_REG_RESET;
    end else if (wr_i) begin
      if (sel_i == `UEDB_REG_IN_SIZE) begin
        in_size_o <= wdata_i & `UEDB_FIELD_MASK;
      end
      if (sel_i == `UEDB_REG_OUT_SIZE) begin
        out_size_o <= wdata_i & `UEDB_FIELD_MASK;
      end
    end
  end

  // read view of the entry, unused slot reads zero
  always_comb begin
    unique case (sel_i)
      `UEDB_REG_CONFIG: rdata_o = cfg_o;
      `UEDB_REG_X_BASE: rdata_o = x_base_o;
      `UEDB_REG_X_COUNT: rdata_o = x_count_o;
      `UEDB_REG_Y_BASE: rdata_o = y_base_o;
      `UEDB_REG_Y_COUNT: rdata_o = y_count_o;
      `UEDB_REG_IN_SIZE: rdata_o = in_size_o;
      `UEDB_REG_OUT_SIZE: rdata_o = out_size_o;
      default: rdata_o = 8'h00;
    endcase
  end
endmodule : uedb_entry

// >>> logic/uedb_device.sv
`timescale 1ns/1ns
`include "uedb_consts.svh"
module uedb_device
  import uedb_pkg::*;
#(
  parameter int ENDPOINTS = `UEDB_ENDPOINTS
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  uedb_link_if.device LINK,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic IRQ_O
);
  logic [7:0] cfg [ENDPOINTS];
  logic [7:0] x_base [ENDPOINTS];
  logic [7:0] x_count [ENDPOINTS];
  logic [7:0] y_base [ENDPOINTS];
  logic [7:0] y_count [ENDPOINTS];
  logic [7:0] in_size [ENDPOINTS];
  logic [7:0] out_size [ENDPOINTS];
  logic [7:0] ep_rdata [ENDPOINTS];
  logic [ENDPOINTS-1:0] ep_hit;
  logic [ENDPOINTS-1:0] stall_clr;
  logic [ENDPOINTS-1:0] done;
  logic [ENDPOINTS-1:0] irq_status;
  logic [ENDPOINTS-1:0] irq_mask;
  logic [ENDPOINTS-1:0] irq_set;
  uedb_dev_state_t state;
  logic [1:0] pend_idx;
  logic pend_y;
  logic [1:0] tok_idx;
  logic tok_hit;
  logic [7:0] cur_cfg;
  uedb_rsp_t next_code;
  logic next_pid;
  logic [10:0] next_addr;
  logic [6:0] next_count;
  logic next_use_y;
  logic [7:0] next_rdata;

  // endpoint number from a register address, zero when the address is not an entry
  function automatic logic [1:0] ep_of(input logic [7:0] addr);
    if (addr[7:5] == 3'h0 && addr[2:0] <= `UEDB_REG_OUT_SIZE) begin
      return addr[4:3];
    end
    return 2'h0;
  endfunction : ep_of

  // token decode; endpoint 0 is not served by this block
  assign tok_hit = LINK.tok_valid && LINK.tok_ep != 2'h0;
  assign tok_idx = LINK.tok_ep - 2'h1;
  assign cur_cfg = cfg[tok_idx];

  // one descriptor entry per endpoint
  genvar g;
  generate
    for (g = 0; g < ENDPOINTS; g++) begin : g_ep
      assign ep_hit[g] = ep_of(REG_ADDR_I) == 2'(g + 1);
      // clear stall once STALL is sent
      assign stall_clr[g] = tok_hit && LINK.tok_in && tok_idx == 2'(g) && next_code == UEDB_RSP_STALL;
      assign done[g] = state == UEDB_D_WAIT_ACK && LINK.hs_ack && pend_idx == 2'(g);
      assign irq_set[g] = done[g] && cfg[g][`UEDB_CFG_IRQ_EN];
      uedb_entry u_entry (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .wr_i(REG_WR_I && ep_hit[g]),
        .sel_i(REG_ADDR_I[2:0]),
        .wdata_i(REG_WDATA_I),
        .stall_clr_i(stall_clr[g]),
        .done_i(done[g]),
        .done_y_i(pend_y),
        .cfg_o(cfg[g]),
        .x_base_o(x_base[g]),
        .x_count_o(x_count[g]),
        .y_base_o(y_base[g]),
        .y_count_o(y_count[g]),
        .in_size_o(in_size[g]),
        .out_size_o(out_size[g]),
        .rdata_o(ep_rdata[g])
      );
    end
  endgenerate

  // answer to a token, worked out in the cycle the token is seen
  always_comb begin
    next_code = UEDB_RSP_NONE;
    next_pid = 1'b0;
    next_addr = 11'h000;
    next_count = 7'h00;
    next_use_y = 1'b0;
    if (tok_hit && cur_cfg[`UEDB_CFG_MGR_EN]) begin
      if (!LINK.tok_in) begin
        // out size reported to the host side
        next_code = UEDB_RSP_SIZE;
        next_count = out_size[tok_idx][6:0];
      end else if (cur_cfg[`UEDB_CFG_STALL]) begin
        next_code = UEDB_RSP_STALL;
      end else begin
        // single buffer mode uses X only
        next_use_y = cur_cfg[`UEDB_CFG_DOUBLE_BUF] & cur_cfg[`UEDB_CFG_TOGGLE];
        next_pid = cur_cfg[`UEDB_CFG_TOGGLE];
        if (next_use_y) begin
          next_addr = {y_base[tok_idx], 3'b000};
          next_count = y_count[tok_idx][6:0];
          next_code = y_count[tok_idx][`UEDB_CNT_NAK] ? UEDB_RSP_NAK : UEDB_RSP_DATA;
        end else begin
          next_addr = {x_base[tok_idx], 3'b000};
          // counts above 64 are not guarded
          next_count = x_count[tok_idx][6:0];
          next_code = x_count[tok_idx][`UEDB_CNT_NAK] ? UEDB_RSP_NAK : UEDB_RSP_DATA;
        end
      end
    end
  end

  // response registers; valid is a one-cycle pulse after the token
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_code <= UEDB_RSP_NONE;
      LINK.rsp_pid <= 1'b0;
      LINK.rsp_addr <= 11'h000;
      LINK.rsp_count <= 7'h00;
    end else begin
      LINK.rsp_valid <= tok_hit;
      if (tok_hit) begin
        LINK.rsp_code <= next_code;
        LINK.rsp_pid <= next_pid;
        LINK.rsp_addr <= next_addr;
        LINK.rsp_count <= next_count;
      end
    end
  end

  // transaction tracking: a data packet waits for the host ACK, a new token abandons it
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= UEDB_D_IDLE;
      pend_idx <= 2'h0;
      pend_y <= 1'b0;
    end else if (tok_hit) begin
      state <= next_code == UEDB_RSP_DATA ? UEDB_D_WAIT_ACK : UEDB_D_IDLE;
      pend_idx <= tok_idx;
      pend_y <= next_use_y;
    end else if (LINK.hs_ack) begin
      state <= UEDB_D_IDLE;
    end
  end

  // sticky completion status, cleared by reading it; a new event in that cycle wins
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_status <= '0;
    end else if (REG_RD_I && REG_ADDR_I == `UEDB_ADDR_IRQ_STATUS) begin
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_mask <= '0;
    end else if (REG_WR_I && REG_ADDR_I == `UEDB_ADDR_IRQ_MASK) begin
      irq_mask <= REG_WDATA_I[ENDPOINTS-1:0];
    end
  end

  assign IRQ_O = |(irq_status & irq_mask);

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (REG_ADDR_I == `UEDB_ADDR_IRQ_STATUS) begin
      next_rdata = 8'(irq_status);
    end else if (REG_ADDR_I == `UEDB_ADDR_IRQ_MASK) begin
      next_rdata = 8'(irq_mask);
    end else if (ep_of(REG_ADDR_I) != 2'h0) begin
      next_rdata = ep_rdata[ep_of(REG_ADDR_I) - 2'h1];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= REG_RD_I ? next_rdata : 8'h00;
    end
  end
endmodule : uedb_device

// >>> logic/uedb_host.sv
`timescale 1ns/1ns
`include "uedb_consts.svh"
// host end: issues one token at a time and acknowledges every data packet
module uedb_host
  import uedb_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  uedb_link_if.host LINK,
  input wire logic CMD_VALID_I,
  input wire logic CMD_IN_I,
  input wire logic [1:0] CMD_EP_I,
  output logic CMD_READY_O,
  output logic RES_VALID_O,
  output uedb_rsp_t RES_CODE_O,
  output logic RES_PID_O,
  output logic [10:0] RES_ADDR_O,
  output logic [6:0] RES_COUNT_O
);
  uedb_host_state_t state;
  logic take;
  logic got;

  // no new token while the ACK of the last packet is on the link
  assign CMD_READY_O = state == UEDB_H_IDLE && !LINK.hs_ack;
  assign take = CMD_VALID_I && CMD_READY_O;
  assign got = state == UEDB_H_WAIT_RSP && LINK.rsp_valid;

  // token driving and wait for the answer
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= UEDB_H_IDLE;
      LINK.tok_valid <= 1'b0;
      LINK.tok_in <= 1'b0;
      LINK.tok_ep <= 2'h0;
    end else begin
      LINK.tok_valid <= take;
      if (take) begin
        LINK.tok_in <= CMD_IN_I;
        LINK.tok_ep <= CMD_EP_I;
        state <= UEDB_H_WAIT_RSP;
      end else if (got || LINK.tok_valid && LINK.tok_ep == 2'h0) begin
        // endpoint 0 tokens get no answer from this block
        state <= UEDB_H_IDLE;
      end
    end
  end

  // only bulk style handshakes are used
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINK.hs_ack <= 1'b0;
    end else begin
      LINK.hs_ack <= got && LINK.tok_in && LINK.rsp_code == UEDB_RSP_DATA;
    end
  end

  // results to the user, one-cycle valid
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RES_VALID_O <= 1'b0;
      RES_CODE_O <= UEDB_RSP_NONE;
      RES_PID_O <= 1'b0;
      RES_ADDR_O <= 11'h000;
      RES_COUNT_O <= 7'h00;
    end else begin
      RES_VALID_O <= got;
      if (got) begin
        RES_CODE_O <= LINK.rsp_code;
        RES_PID_O <= LINK.rsp_pid;
        RES_ADDR_O <= LINK.rsp_addr;
        RES_COUNT_O <= LINK.rsp_count;
      end
    end
  end
endmodule : uedb_host

// >>> tb/uedb_checker.sv
`timescale 1ns/1ns
// watches the link between the two ends; everything here is driven by design code
module uedb_checker
  import uedb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tok_valid_i,
  input wire logic tok_in_i,
  input wire logic [1:0] tok_ep_i,
  input wire logic rsp_valid_i,
  input wire uedb_rsp_t rsp_code_i,
  input wire logic rsp_pid_i,
  input wire logic [10:0] rsp_addr_i,
  input wire logic [6:0] rsp_count_i,
  input wire logic hs_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_answer_one_later: assert property (
    tok_valid_i && tok_ep_i != 2'h0 |=> rsp_valid_i)
    else $error("no answer one cycle after a token");
  chk_no_stray_answer: assert property (
    rsp_valid_i |-> $past(tok_valid_i) && $past(tok_ep_i) != 2'h0)
    else $error("answer without a served token");
  chk_start_addr_align: assert property (
    rsp_valid_i && rsp_code_i == UEDB_RSP_DATA |-> rsp_addr_i[2:0] == 3'h0)
    else $error("buffer start address not on an eight byte boundary");
  chk_count_in_range: assert property (
    rsp_valid_i && rsp_code_i inside {UEDB_RSP_DATA, UEDB_RSP_SIZE} |-> rsp_count_i <= 7'h40)
    else $error("byte count above 64");
  chk_out_gets_size: assert property (
    rsp_valid_i && !$past(tok_in_i) |-> rsp_code_i inside {UEDB_RSP_SIZE, UEDB_RSP_NONE})
    else $error("out token not answered with the buffer size");
  chk_in_no_size: assert property (
    rsp_valid_i && $past(tok_in_i) |-> rsp_code_i != UEDB_RSP_SIZE)
    else $error("in token answered with a size");
  chk_fields_hold: assert property (
    !rsp_valid_i |-> $stable(rsp_code_i) && $stable(rsp_addr_i) && $stable(rsp_count_i) && $stable(rsp_pid_i))
    else $error("answer fields moved without a new answer");
  chk_ack_after_data: assert property (
    hs_ack_i |-> $past(rsp_valid_i) && $past(rsp_code_i) == UEDB_RSP_DATA)
    else $error("acknowledge without a data packet");
  // a served token needs its answer and the host turnaround: two quiet cycles at least
  chk_token_spacing: assert property (
    tok_valid_i && tok_ep_i != 2'h0 |=> !tok_valid_i [*2])
    else $error("tokens closer than one transaction");
endmodule : uedb_checker

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  import uedb_pkg::*;
  typedef struct packed {uedb_rsp_t code; logic pid; logic [10:0] addr; logic [6:0] count;} uedb_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic cmd_valid = 1'b0;
  logic cmd_in = 1'b0;
  logic [1:0] cmd_ep = 2'h0;
  logic cmd_ready;
  logic res_valid;
  uedb_rsp_t res_code;
  logic res_pid;
  logic [10:0] res_addr;
  logic [6:0] res_count;
  logic rd_d = 1'b0;
  logic [7:0] rd_q[$];
  uedb_exp_t res_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  uedb_link_if link ();
  uedb_device uedb_device_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(link), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .IRQ_O(irq));
  uedb_host uedb_host_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(link), .CMD_VALID_I(cmd_valid),
    .CMD_IN_I(cmd_in), .CMD_EP_I(cmd_ep), .CMD_READY_O(cmd_ready), .RES_VALID_O(res_valid),
    .RES_CODE_O(res_code), .RES_PID_O(res_pid), .RES_ADDR_O(res_addr), .RES_COUNT_O(res_count));
  uedb_checker uedb_checker_inst (.clk_i(clk), .rst_n_i(rst_n), .tok_valid_i(link.tok_valid),
    .tok_in_i(link.tok_in), .tok_ep_i(link.tok_ep), .rsp_valid_i(link.rsp_valid), .rsp_code_i(link.rsp_code),
    .rsp_pid_i(link.rsp_pid), .rsp_addr_i(link.rsp_addr), .rsp_count_i(link.rsp_count),
    .hs_ack_i(link.hs_ack));

  // bench clock, 50 ns period
  always #25 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp_res(input uedb_exp_t got, input uedb_exp_t exp);
    uedb_exp_t m;
    m = got;
    // fields that an answer kind leaves undefined are not judged
    if (exp.code != UEDB_RSP_DATA) begin
      m.pid = exp.pid;
      m.addr = exp.addr;
    end
    if (exp.code != UEDB_RSP_DATA && exp.code != UEDB_RSP_SIZE) m.count = exp.count;
    cmp_count++;
    if (m !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_res

  task automatic reg_wr_op(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : reg_wr_op

  task automatic reg_rd_op(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_q.push_back(e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
  endtask : reg_rd_op

  task automatic bus_idle;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : bus_idle

  // host command; the wait on ready is cut short by the cycle ceiling
  task automatic cmd(input logic in, input logic [1:0] ep, input uedb_exp_t e);
    if (ep != 2'h0) res_q.push_back(e);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_in <= in;
    cmd_ep <= ep;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : cmd

  task automatic irq_check(input logic e);
    bus_idle();
    @(negedge clk);
    cmp8({7'h0, irq}, {7'h0, e});
  endtask : irq_check

  task automatic end_sim;
    error_cnt += rd_q.size() + res_q.size();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) cmp8(reg_rdata, rd_q.pop_front());
    rd_d <= reg_rd;
  end

  // every host result takes the oldest note
  always @(posedge clk) begin
    if (res_valid === 1'b1) cmp_res({res_code, res_pid, res_addr, res_count}, res_q.pop_front());
  end

  // cycle ceiling; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    logic [31:0] rnd;
    logic [7:0] xb;
    logic [7:0] yb;
    logic [6:0] xc;
    logic [6:0] yc;
    rnd = 32'hF1DD;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int e = 1; e <= 3; e++) for (int r = 0; r <= 6; r++) reg_rd_op({3'h0, 2'(e), 3'(r)}, 8'h00);
    reg_rd_op(8'h0F, 8'h00);
    reg_wr_op(8'h0E, 8'hC0);
    reg_rd_op(8'h0E, 8'h40);
    reg_wr_op(8'h0D, 8'hC0);
    reg_rd_op(8'h0D, 8'h40);
    rnd = lfsr(rnd);
    xb = rnd[7:0];
    xc = 7'(rnd[15:8] % 65);
    reg_wr_op(8'h09, xb);
    reg_wr_op(8'h0A, {1'b0, xc});
    reg_wr_op(8'h08, 8'h87);
    reg_rd_op(8'h08, 8'h84);
    bus_idle();
    cmd(1'b0, 2'd1, '{UEDB_RSP_SIZE, 1'b0, 11'h0, 7'h40});
    cmd(1'b1, 2'd2, '{UEDB_RSP_NONE, 1'b0, 11'h0, 7'h0});
    cmd(1'b1, 2'd1, '{UEDB_RSP_DATA, 1'b0, {xb, 3'h0}, xc});
    cmd(1'b1, 2'd1, '{UEDB_RSP_NAK, 1'b0, 11'h0, 7'h0});
    cmd(1'b1, 2'd0, '{UEDB_RSP_NONE, 1'b0, 11'h0, 7'h0});
    reg_rd_op(8'h0A, {1'b1, xc});
    reg_rd_op(8'h09, xb);
    reg_rd_op(8'h08, 8'hA4);
    irq_check(1'b0);
    reg_wr_op(8'h01, 8'h01);
    irq_check(1'b1);
    reg_rd_op(8'h00, 8'h01);
    irq_check(1'b0);
    reg_wr_op(8'h10, 8'h88);
    bus_idle();
    cmd(1'b1, 2'd2, '{UEDB_RSP_STALL, 1'b0, 11'h0, 7'h0});
    reg_rd_op(8'h10, 8'h80);
    rnd = lfsr(rnd);
    yb = rnd[7:0];
    yc = 7'(rnd[23:16] % 65);
    reg_wr_op(8'h19, xb);
    reg_wr_op(8'h1A, {1'b0, xc});
    reg_wr_op(8'h1B, yb);
    reg_wr_op(8'h1C, {1'b0, yc});
    reg_wr_op(8'h18, 8'h90);
    bus_idle();
    cmd(1'b1, 2'd3, '{UEDB_RSP_DATA, 1'b0, {xb, 3'h0}, xc});
    cmd(1'b1, 2'd3, '{UEDB_RSP_DATA, 1'b1, {yb, 3'h0}, yc});
    cmd(1'b1, 2'd3, '{UEDB_RSP_NAK, 1'b0, 11'h0, 7'h0});
    reg_rd_op(8'h1C, {1'b1, yc});
    reg_rd_op(8'h1B, yb);
    reg_rd_op(8'h18, 8'h90);
    reg_rd_op(8'h00, 8'h00);
    bus_idle();
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : tb
